//--- core/reg_word_mem.sv
`default_nettype none
// Word memory holding either the staging or the active copy of the map.
module reg_word_mem
    import synth_map_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Byte write port.
    input  wire logic        wr_en,
    input  wire logic [4:0]  wr_word,
    input  wire logic [3:0]  wr_lanes,
    input  wire logic [31:0] wr_data,
    // Whole copy load.
    input  wire logic        load_all,
    input  wire logic [31:0] load_data [NUM_WORDS],
    // Contents.
    output logic      [31:0] words     [NUM_WORDS]
);
    // Reset values per word; user sync word has nonzero default.
    function automatic logic [31:0] def_of(input int i);
        def_of = (i == int'(ADDR_USER_SYNC)) ? USER_SYNC_DEF : DEFAULT_WORD;
    endfunction

    // Store with reset defaults, whole-copy load, or byte writes.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                words[i] <= def_of(i);
            end
        end else begin
            for (int i = 0; i < NUM_WORDS; i++) begin
                if (load_all) begin
                    words[i] <= load_data[i];
                end else if (wr_en && wr_word == 5'(i)) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wr_lanes[b]) begin
                            words[i][b*8 +: 8] <= wr_data[b*8 +: 8];
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- core/synth_map_pkg.sv
`default_nettype none
package synth_map_pkg;
    localparam int          NUM_WORDS      = 28;
    localparam int          NUM_BYTES      = 112;
    localparam logic [4:0]  LAST_WORD      = 5'h1b;
    localparam logic [6:0]  LAST_BYTE      = 7'h6f;
    localparam logic [4:0]  ADDR_PROFILE7  = 5'h1a;
    localparam logic [4:0]  ADDR_USER_SYNC = 5'h1b;
    localparam logic [4:0]  ADDR_CTRL_ONE  = 5'h00;
    // Word holding the DAC calibration enable; its placement is a plain default.
    localparam logic [4:0]  ADDR_DAC_CAL   = 5'h03;
    // Defaults of words without a shown value; named so they can be set.
    localparam logic [31:0] DEFAULT_WORD   = 32'h0000_0000;
    localparam logic [31:0] USER_SYNC_DEF  = 32'h0000_0800;
    localparam logic [31:0] USER_SYNC_WMSK = 32'h00ff_ffff;
    localparam int          LOCK_BIT       = 24;
    localparam int          CAL_BIT        = 24;
    localparam int          STREAM_BIT     = 17;
    localparam int          POW_LSB        = 0;
    localparam int          POW_W          = 16;
    localparam int          ASF_LSB        = 16;
    localparam int          ASF_W          = 12;
    localparam int          SYNC_IN_LSB    = 0;
    localparam int          SYNC_OUT_LSB   = 3;
    localparam int          TRIM_W         = 3;
    // Calibration routine length in nanoseconds, rounded up to whole core clocks of CLK_NS.
    localparam int          CAL_NS         = 2000;
    localparam int          CLK_NS         = 20;
    localparam int          CAL_CYCLES     = (CAL_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  CAL_CNT_LAST   = 8'(CAL_CYCLES - 1);
endpackage
`default_nettype wire

//--- core/synth_register_map_tail.sv
`default_nettype none
// Host port register map with buffered writes and committed copy.
// The host writes a staging copy; a commit copies the whole map at once into
// the active copy, which alone drives the field outputs.
module synth_register_map_tail
    import synth_map_pkg::*;
(
    // Clock and master reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Port mode: high selects byte-parallel addressing.
    input  wire logic        parallel_mode,
    // Host write/read request.
    input  wire logic        wr_req,
    input  wire logic        rd_req,
    input  wire logic [6:0]  addr,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] rd_data,
    output logic             rd_valid,
    // Commit pins from outside the clock domain.
    input  wire logic        io_update,
    input  wire logic [2:0]  profile_sel,
    // Parallel data port.
    input  wire logic [31:0] par_data,
    input  wire logic        par_valid,
    output logic      [31:0] par_active,
    // Status from the synthesis core.
    input  wire logic        pll_lock,
    // Active profile seven, user sync and control word one fields.
    output logic      [15:0] profile_seven_phase,
    output logic      [11:0] profile_seven_amplitude,
    output logic      [2:0]  sync_input_delay_trim,
    output logic      [2:0]  sync_output_delay_trim,
    output logic             stream_enable,
    // Calibration routine status.
    output logic             dac_cal_busy,
    output logic      [3:0]  dac_capture_trim
);
    // Byte-parallel address decode helpers: the word is the address over four,
    // and the lane is the remainder, lane 0 holding bits 7 to 0.
    function automatic logic [4:0] word_of(input logic [6:0] a);
        word_of = a[6:2];
    endfunction

    function automatic logic [1:0] lane_of(input logic [6:0] a);
        lane_of = a[1:0];
    endfunction

    // Range checks for the two addressing modes. A serial address past the last
    // word, or with its two top bits set, selects nothing; so does a byte address
    // past the last byte. Such writes are dropped and such reads return zero.
    wire logic        serial_ok = (addr[6:5] == 2'b00) && (addr[4:0] <= LAST_WORD);
    wire logic        byte_ok   = (addr <= LAST_BYTE);
    wire logic        addr_ok   = parallel_mode ? byte_ok : serial_ok;

    // Word, lane enables and data of the request. A byte write copies its byte
    // to all four lanes, so the lane enable alone picks the destination.
    wire logic [4:0]  req_word  = parallel_mode ? word_of(addr) : addr[4:0];
    wire logic [3:0]  req_lanes = parallel_mode ? (4'h1 << lane_of(addr)) : 4'hf;
    wire logic [31:0] req_data  = parallel_mode ? {4{wr_data[7:0]}} : wr_data;
    // Top user sync byte is read-only, so lane 3 is never written there.
    wire logic [3:0]  wr_lanes  = (req_word == ADDR_USER_SYNC) ? (req_lanes & 4'h7) : req_lanes;
    wire logic        do_write  = wr_req && addr_ok;

    // Three-stage synchronisers for the commit pins and lock input. The pins come
    // from outside the core clock, so only stages two and three are compared;
    // stage one may be metastable and feeds nothing but stage two.
    logic [2:0] upd_s_r;
    logic [2:0] ps0_s_r;
    logic [2:0] ps1_s_r;
    logic [2:0] ps2_s_r;
    logic [2:0] lock_s_r;
    logic       upd_st_r;
    logic [2:0] ps_st_r;
    logic       lock_st_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            upd_s_r  <= 3'h0;
            ps0_s_r  <= 3'h0;
            ps1_s_r  <= 3'h0;
            ps2_s_r  <= 3'h0;
            lock_s_r <= 3'h0;
        end else begin
            upd_s_r  <= {upd_s_r[1:0], io_update};
            ps0_s_r  <= {ps0_s_r[1:0], profile_sel[0]};
            ps1_s_r  <= {ps1_s_r[1:0], profile_sel[1]};
            ps2_s_r  <= {ps2_s_r[1:0], profile_sel[2]};
            lock_s_r <= {lock_s_r[1:0], pll_lock};
        end
    end

    // Accept a level once stages two and three agree, which filters a pin that
    // bounces for a single clock.
    wire logic       upd_agree = (upd_s_r[1] == upd_s_r[2]);
    wire logic [2:0] ps_mid    = {ps2_s_r[1], ps1_s_r[1], ps0_s_r[1]};
    wire logic [2:0] ps_old    = {ps2_s_r[2], ps1_s_r[2], ps0_s_r[2]};
    wire logic       ps_agree  = (ps_mid == ps_old);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            upd_st_r  <= 1'b0;
            ps_st_r   <= 3'h0;
            lock_st_r <= 1'b0;
        end else begin
            if (upd_agree) upd_st_r <= upd_s_r[2];
            if (ps_agree) ps_st_r <= ps_old;
            if (lock_s_r[1] == lock_s_r[2]) lock_st_r <= lock_s_r[2];
        end
    end

    // Commit on a rising update strobe or any profile change.
    // Both detectors compare against the accepted level, so each pin event
    // yields exactly one commit pulse however long the pin is held.
    wire logic upd_rise = upd_agree && upd_s_r[2] && !upd_st_r;
    wire logic ps_chg   = ps_agree && (ps_old != ps_st_r);
    wire logic commit   = upd_rise || ps_chg;

    // Staging copy written by the host, active copy loaded on commit.
    // The staging copy never loads as a whole and the active copy never takes
    // byte writes, so those ports are tied off.
    logic [31:0] stage_w  [NUM_WORDS];
    logic [31:0] active_w [NUM_WORDS];
    logic [31:0] unused_in [NUM_WORDS];
    always_comb begin
        for (int i = 0; i < NUM_WORDS; i++) unused_in[i] = DEFAULT_WORD;
    end

    reg_word_mem u_stage (
        .clk       (clk),
        .rstn      (rstn),
        .wr_en     (do_write),
        .wr_word   (req_word),
        .wr_lanes  (wr_lanes),
        .wr_data   (req_data),
        .load_all  (1'b0),
        .load_data (unused_in),
        .words     (stage_w)
    );

    reg_word_mem u_active (
        .clk       (clk),
        .rstn      (rstn),
        .wr_en     (1'b0),
        .wr_word   (ADDR_CTRL_ONE),
        .wr_lanes  (4'h0),
        .wr_data   (DEFAULT_WORD),
        .load_all  (commit),
        .load_data (stage_w),
        .words     (active_w)
    );

    // Read mux: reads return the staging word, so a host can check what it wrote
    // before committing. The top user sync byte is replaced by the synchronised
    // lock status, and the rest of that byte reads as zero.
    wire logic [31:0] rd_word  = stage_w[req_word];
    wire logic [31:0] rd_lock  = 32'(lock_st_r) << LOCK_BIT;
    wire logic [31:0] rd_fixed = (req_word == ADDR_USER_SYNC) ? ((rd_word & USER_SYNC_WMSK) | rd_lock) : rd_word;
    wire logic [7:0]  rd_byte  = rd_fixed[lane_of(addr)*8 +: 8];
    wire logic [31:0] rd_pick  = parallel_mode ? {24'h00_0000, rd_byte} : rd_fixed;

    // Read answer register; unmapped addresses read as zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data  <= 32'h0000_0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            if (rd_req) begin
                rd_data <= addr_ok ? rd_pick : 32'h0000_0000;
            end
        end
    end

    // Field extraction from the active copy as unsigned words.
    // Bit 0 of each field is its least significant bit.
    wire logic [31:0] p7_w   = active_w[ADDR_PROFILE7];
    wire logic [31:0] usr_w  = active_w[ADDR_USER_SYNC];
    wire logic [31:0] ctl1_w = active_w[ADDR_CTRL_ONE];
    assign profile_seven_phase     = p7_w[POW_LSB +: POW_W];
    assign profile_seven_amplitude = p7_w[ASF_LSB +: ASF_W];
    assign sync_input_delay_trim   = usr_w[SYNC_IN_LSB +: TRIM_W];
    assign sync_output_delay_trim  = usr_w[SYNC_OUT_LSB +: TRIM_W];
    assign stream_enable           = ctl1_w[STREAM_BIT];

    // Parallel port: streaming passes data, otherwise hold until update.
    // Only the update strobe applies held data; a profile change does not,
    // and a strobe on the edge that turns streaming off applies nothing.
    logic [31:0] par_hold_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            par_hold_r <= 32'h0000_0000;
            par_active <= 32'h0000_0000;
        end else begin
            if (par_valid) par_hold_r <= par_data;
            if (stream_enable && par_valid) par_active <= par_data;
            else if (!stream_enable && upd_rise) par_active <= par_hold_r;
        end
    end

    // Calibration routine: starts on the cal bit rising in the active copy, so a
    // set written to staging does nothing until it is committed. The host must
    // clear the bit and commit again before a second routine can start. While
    // busy, the capture trim steps with the upper counter bits.
    logic             cal_prev_r;
    logic [7:0]       cal_cnt_r;
    wire logic [31:0] cal_w     = active_w[ADDR_DAC_CAL];
    wire logic        cal_bit   = cal_w[CAL_BIT];
    wire logic        cal_start = cal_bit && !cal_prev_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cal_prev_r       <= 1'b0;
            cal_cnt_r        <= 8'h00;
            dac_cal_busy     <= 1'b0;
            dac_capture_trim <= 4'h0;
        end else begin
            cal_prev_r <= cal_bit;
            if (cal_start) begin
                dac_cal_busy     <= 1'b1;
                cal_cnt_r        <= 8'h00;
                dac_capture_trim <= 4'h0;
            end else if (dac_cal_busy) begin
                cal_cnt_r        <= cal_cnt_r + 8'h01;
                dac_capture_trim <= cal_cnt_r[7:4];
                if (cal_cnt_r == CAL_CNT_LAST) dac_cal_busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/host_port.sv
`default_nettype none
// Host controller model; changes its outputs just after falling edges.
module host_port (
    // Clock and read answer.
    input  wire logic        clk,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_valid,
    // Requests and commit pins.
    output logic             wr_req,
    output logic             rd_req,
    output logic             io_update,
    output logic             par_valid,
    output logic      [2:0]  profile_sel,
    output logic      [6:0]  addr,
    output logic      [31:0] wr_data,
    output logic      [31:0] par_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle levels at time zero.
    initial begin
        {wr_req, rd_req, io_update, par_valid, profile_sel, addr} = '0;
        wr_data  = 32'h0;
        par_data = 32'h0;
    end
    // One-cycle write pulse.
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(negedge clk);
        addr    = a;
        wr_data = d;
        wr_req  = 1'b1;
        @(negedge clk);
        wr_req  = 1'b0;
        wr_data = ~d;
    endtask
    // Read pulse; the answer stands only in the cycle after the request.
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(negedge clk);
        addr   = a;
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
        d      = rd_valid ? rd_data : 32'hx;
    endtask
    // Update strobe held well past the three-edge sync, then settle.
    task automatic strobe();
        @(negedge clk);
        io_update = 1'b1;
        repeat (4) @(negedge clk);
        io_update = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    // Profile pin change commits like a strobe.
    task automatic prof();
        @(negedge clk);
        profile_sel = profile_sel + 3'h1;
        repeat (8) @(negedge clk);
    endtask
    // Present one word on the parallel port.
    task automatic par(input logic [31:0] d);
        @(negedge clk);
        par_data  = d;
        par_valid = 1'b1;
        @(negedge clk);
        par_valid = 1'b0;
        par_data  = ~d;
        repeat (2) @(negedge clk);
    endtask
endmodule
`default_nettype wire

//--- dv/map_checker_asserts.sv
`default_nettype none
// Port checker for the register map; sees only top-level ports.
module map_checker_asserts (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rstn,
    // Host requests and read answer.
    input wire logic        parallel_mode,
    input wire logic        rd_req,
    input wire logic [6:0]  addr,
    input wire logic [31:0] rd_data,
    input wire logic        rd_valid,
    // Commit pins and applied outputs.
    input wire logic        io_update,
    input wire logic [2:0]  profile_sel,
    input wire logic [31:0] par_active,
    input wire logic [15:0] profile_seven_phase,
    input wire logic [11:0] profile_seven_amplitude,
    input wire logic        stream_enable,
    input wire logic        dac_cal_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] quiet_r;
    logic [3:0] quiet_nxt;
    logic [3:0] pins_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Cycles since the commit pins last moved; commits land within a few edges.
    assign quiet_nxt = (pins_r != {io_update, profile_sel}) ? 4'h0 : (quiet_r == 4'hf ? quiet_r : quiet_r + 4'h1);
    // Track pins and quiet count.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            quiet_r <= 4'h0;
            pins_r  <= 4'h0;
        end else begin
            quiet_r <= quiet_nxt;
            pins_r  <= {io_update, profile_sel};
        end
    end
    read_answer_a: assert property (rd_req |=> rd_valid) else $error("read not answered");
    read_pulse_a: assert property (!rd_req |=> !rd_valid) else $error("stray read valid");
    word_unmapped_a: assert property (rd_req && !parallel_mode && addr > 7'h1b |=> rd_data == 32'h0)
        else $error("unmapped word read not zero");
    byte_unmapped_a: assert property (rd_req && parallel_mode && addr > 7'h6f |=> rd_data == 32'h0)
        else $error("unmapped byte read not zero");
    byte_lane_a: assert property (rd_req && parallel_mode |=> rd_data[31:8] == 24'h0)
        else $error("byte read wider than a byte");
    lock_open_a: assert property (rd_req && !parallel_mode && addr == 7'h1b |=> rd_data[31:25] == 7'h0)
        else $error("open status bits set");
    hold_fields_a: assert property (quiet_r >= 4'h7 |-> $stable(profile_seven_phase) && $stable(stream_enable)
        && $stable(profile_seven_amplitude)) else $error("active field moved without commit");
    stream_off_a: assert property (quiet_r >= 4'h7 && !stream_enable |-> $stable(par_active))
        else $error("parallel data applied without strobe");
    reset_default_a: assert property ($rose(rstn) |-> profile_seven_phase == 16'h0 && !dac_cal_busy)
        else $error("field not at default after reset");
    cal_commit_a: assert property (quiet_r >= 4'h7 |-> !$rose(dac_cal_busy))
        else $error("calibration started without commit");
endmodule
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
// Register map bench: host calls with expected values.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import synth_map_pkg::*;
    logic clk, rstn, parallel_mode, pll_lock, wr_req, rd_req, rd_valid, io_update, par_valid, stream_enable, dac_cal_busy;
    logic [6:0] addr;
    logic [2:0] profile_sel, sync_input_delay_trim, sync_output_delay_trim;
    logic [31:0] wr_data, rd_data, par_data, par_active, d;
    logic [31:0] exp7 = 32'h0abc_1234;
    logic [15:0] profile_seven_phase;
    logic [11:0] profile_seven_amplitude;
    logic [3:0] dac_capture_trim;
    // Calibration enable and streaming enable as the host writes them.
    localparam logic [6:0]  CAL_ADDR   = {2'b00, ADDR_DAC_CAL};
    localparam logic [31:0] CAL_SET    = 32'h0000_0001 << CAL_BIT;
    localparam logic [31:0] STREAM_SET = 32'h0000_0001 << STREAM_BIT;
    int fails = 0, samples_checked = 0, cyc = 0;
    synth_register_map_tail DUT (.clk, .rstn, .parallel_mode, .wr_req, .rd_req, .addr, .wr_data, .rd_data, .rd_valid,
        .io_update, .profile_sel, .par_data, .par_valid, .par_active, .pll_lock, .profile_seven_phase,
        .profile_seven_amplitude, .sync_input_delay_trim, .sync_output_delay_trim, .stream_enable, .dac_cal_busy,
        .dac_capture_trim);
    host_port host (.clk, .rd_data, .rd_valid, .wr_req, .rd_req, .io_update, .par_valid, .profile_sel, .addr,
        .wr_data, .par_data);
    // Comparison with count.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Report and stop.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One set-then-clear calibration pass: busy rises once the set is committed
    // and falls within the routine length after it.
    task automatic run_cal();
        host.wr(CAL_ADDR, CAL_SET);
        host.strobe(); chk({31'h0, dac_cal_busy}, 32'h1);
        host.wr(CAL_ADDR, 32'h0000_0000);
        host.strobe();
        repeat (CAL_CYCLES) @(negedge clk);
        chk({31'h0, dac_cal_busy}, 32'h0);
        chk({31'h0, dac_capture_trim != 4'h0}, 32'h1);
    endtask
    // Clock and hang guard; the ceiling is several times the expected run length.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end
    // Main sequence.
    initial begin
        {rstn, parallel_mode, pll_lock} = 3'b000;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        host.rd(7'h1b, d); chk(d, 32'h0000_0800);
        host.wr(7'h1a, exp7);
        host.rd(7'h1a, d); chk(d, exp7);
        chk({16'h0, profile_seven_phase}, 32'h0);
        host.strobe();
        chk({16'h0, profile_seven_phase}, 32'h1234);
        chk({20'h0, profile_seven_amplitude}, 32'habc);
        parallel_mode = 1'b1;
        for (int i = 0; i < 4; i++) begin
            host.rd(7'h68 + 7'(i), d); chk(d, {24'h0, exp7[8*i+:8]});
        end
        host.wr(7'h68, 32'h55);
        host.prof(); chk({16'h0, profile_seven_phase}, 32'h1255);
        host.rd(7'h70, d); chk(d, 32'h0);
        parallel_mode = 1'b0;
        host.rd(7'h1c, d); chk(d, 32'h0);
        // Let the lock level pass the synchroniser before it is read back.
        pll_lock = 1'b1;
        repeat (4) @(negedge clk);
        host.wr(7'h1b, 32'hff00_082b);
        host.rd(7'h1b, d); chk(d, 32'h0100_082b);
        host.strobe();
        chk({29'h0, sync_input_delay_trim}, 32'h3);
        chk({29'h0, sync_output_delay_trim}, 32'h5);
        host.par(32'h1357_9bdf); chk(par_active, 32'h0);
        host.strobe(); chk(par_active, 32'h1357_9bdf);
        // Streaming on: parallel data applies without a strobe.
        host.wr(7'h00, STREAM_SET);
        host.strobe(); chk({31'h0, stream_enable}, 32'h1);
        host.par(32'h2468_ace0); chk(par_active, 32'h2468_ace0);
        host.wr(7'h00, 32'h0000_0000);
        host.strobe(); chk({31'h0, stream_enable}, 32'h0);
        // Calibration after power-up, then again as after a clock change.
        run_cal();
        run_cal();
        // Master reset in mid-run returns the map to its defaults.
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        chk({16'h0, profile_seven_phase}, 32'h0);
        rstn = 1'b1;
        host.rd(7'h1a, d); chk(d, 32'h0);
        chk({20'h0, profile_seven_amplitude}, 32'h0);
        give_verdict();
    end
endmodule
bind synth_register_map_tail map_checker_asserts chk (.clk, .rstn, .parallel_mode, .rd_req, .addr, .rd_data,
    .rd_valid, .io_update, .profile_sel, .par_active, .profile_seven_phase, .profile_seven_amplitude,
    .stream_enable, .dac_cal_busy);
`default_nettype wire
